// *** include/blm_defines.vh ***
// Register map, field positions, reset values and timing constants of the monitor
`ifndef BLM_DEFINES_VH
`define BLM_DEFINES_VH

`define BLM_CLK_HZ          250000000
`define BLM_TICK_PERIOD_S   1

`define BLM_ADDR_CTRL       8'h00
`define BLM_ADDR_CFG0       8'h10
`define BLM_ADDR_CYC0       8'h14
`define BLM_ADDR_CFG1       8'h18
`define BLM_ADDR_CYC1       8'h1c
`define BLM_ADDR_STATUS     8'h20
`define BLM_ADDR_THR0       8'h24
`define BLM_ADDR_THR1       8'h28

`define BLM_CTRL_ACTIVE     0
`define BLM_CTRL_LV2_EN     1
`define BLM_CTRL_DOWNLOAD   2
`define BLM_CTRL_RST        2'h0

`define BLM_CFG_THR         4:0
`define BLM_CFG_HYS         11:8
`define BLM_CFG_MODE        15:12
`define BLM_CFG_EXT         17:16
`define BLM_CFG_OND         23:20
`define BLM_CFG_OFFD        27:24
`define BLM_CFG_RST         32'h0000_0000

`define BLM_CYC_INT         6:0
`define BLM_CYC_SOC         8
`define BLM_CYC_RST         32'h0000_0000

`define BLM_EXT_NONE        2'h0
`define BLM_EXT_16B         2'h1
`define BLM_EXT_8B          2'h2
`define BLM_EXT_TEACH       2'h3

`define BLM_THR_MIN_KLX     16'h0003
`define BLM_THR_STEP_KLX    16'h0005
`define BLM_THR_CODE_MAX    5'h15
`define BLM_HYS_FINE_MAX    4'h5
`define BLM_HYS_STEP_KLX    16'h000a
`define BLM_CYC_MAX         7'h78
`define BLM_CYC_STEP_S      12'h00a
`define BLM_MODE_MAX        4'hb

`endif

// *** rtl/blm_tick.v ***
// One-second tick prescaler running from the core clock
`timescale 1ns/1ps
module blm_tick #(
  parameter [31:0] CYCLES = 32'd250000000
) (
  input  wire core_clk_i,
  input  wire rst_i,
  output wire tick_o
);
  reg  [31:0] cnt_r;
  reg         tick_r;

  assign tick_o = tick_r;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (cnt_r == CYCLES - 32'h0000_0001) begin
      cnt_r  <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end
endmodule // blm_tick

// *** rtl/blm_sec_timer.v ***
// Seconds down-counter with start, cancel and a one-cycle expiry pulse
`timescale 1ns/1ps
module blm_sec_timer #(
  parameter W = 12
) (
  input  wire         core_clk_i,
  input  wire         rst_i,
  input  wire         tick_i,
  input  wire         start_i,
  input  wire         stop_i,
  input  wire [W-1:0] secs_i,
  output wire         busy_o,
  output wire         done_o
);
  reg  [W-1:0] cnt_r;
  reg          busy_r;
  reg          done_r;

  assign busy_o = busy_r;
  assign done_o = done_r;

  // Start may come between ticks, so the first second can be short by up to one tick
  always @(posedge core_clk_i) begin
    if (rst_i || stop_i) begin
      cnt_r  <= {W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start_i) begin
      cnt_r  <= secs_i;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (busy_r && tick_i) begin
      cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      busy_r <= (cnt_r != {{(W-1){1'b0}}, 1'b1});
      done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end else begin
      done_r <= 1'b0;
    end
  end
endmodule // blm_sec_timer

// *** rtl/blm_top.v ***
// Brightness limit monitor: two limit channels with delays, hysteresis and send control
//
// Contract
// RULE_01 - Teach pulse copies present brightness into the active threshold.
// RULE_02 - Download restores configured threshold until a new external value arrives.
// RULE_03 - A new state of one is accepted only after the selected on-delay.
// RULE_04 - Cyclic sends keep carrying zero while the on-delay runs.
// RULE_05 - A new state of zero is accepted only after the selected off-delay.
// RULE_06 - Cyclic sends keep carrying one while the off-delay runs.
// RULE_07 - A no-transmission condition also suppresses cyclic sends while it holds.
// RULE_08 - Send-on-change off: no send merely because the state changed.
// RULE_09 - Send-on-change on: send at every accepted transition.
// RULE_10 - Interval of one or more sends periodically regardless of change.
// RULE_11 - Interval setting 0 to 120, period is setting times ten seconds.
// RULE_12 - Interval zero disables periodic sending.
// RULE_13 - Change sending off and interval zero: never send.
// RULE_14 - Threshold selectable as 3 kLux or 5 to 105 kLux in fives.
// RULE_15 - Channel two exists only with sensor active and both channels enabled.
// RULE_16 - Set or clear on crossing, hysteresis on the opposite crossing.
// RULE_17 - Twelve modes assign on, off or nothing to each crossing.
// RULE_18 - External threshold arrives as 2-byte or 1-byte value.
// RULE_19 - A running delay is cancelled if the comparison reverts.
// RULE_20 - All timers count a common one-second tick.
`timescale 1ns/1ps
`include "blm_defines.vh"
module blm_top #(
  parameter [31:0] TICK_CYCLES = `BLM_CLK_HZ * `BLM_TICK_PERIOD_S
) (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire [15:0] brightness_i,
  input  wire [15:0] ext_value_i,
  input  wire [1:0]  ext_wr_i,
  input  wire [1:0]  teach_i,
  output wire [1:0]  limit_o,
  output wire [1:0]  send_o
);

  function [15:0] thr_klx;
    input [4:0] code;
    reg   [4:0] c;
    begin
      c = (code > `BLM_THR_CODE_MAX) ? `BLM_THR_CODE_MAX : code;
      if (c == 5'h00) begin
        thr_klx = `BLM_THR_MIN_KLX;
      end else begin
        thr_klx = {11'h000, c} * `BLM_THR_STEP_KLX;
      end
    end
  endfunction

  function [15:0] hys_klx;
    input [3:0] code;
    begin
      if (code <= `BLM_HYS_FINE_MAX) begin
        hys_klx = {12'h000, code};
      end else begin
        hys_klx = ({12'h000, code} - {12'h000, `BLM_HYS_FINE_MAX}) * `BLM_HYS_STEP_KLX;
      end
    end
  endfunction

  // Delay choice to seconds; codes beyond the list saturate at one hour
  function [11:0] delay_s;
    input [3:0] code;
    begin
      case (code)
        4'h0: delay_s = 12'h000;
        4'h1: delay_s = 12'h001;
        4'h2: delay_s = 12'h003;
        4'h3: delay_s = 12'h005;
        4'h4: delay_s = 12'h00a;
        4'h5: delay_s = 12'h00f;
        4'h6: delay_s = 12'h01e;
        4'h7: delay_s = 12'h03c;
        4'h8: delay_s = 12'h0b4;
        4'h9: delay_s = 12'h12c;
        4'ha: delay_s = 12'h258;
        4'hb: delay_s = 12'h384;
        4'hc: delay_s = 12'h708;
        default: delay_s = 12'he10;
      endcase
    end
  endfunction

  // Returns {under, a_en, a_val, b_en, b_val}; a is the primary crossing
  function [4:0] mode_act;
    input [3:0] code;
    begin
      case (code)
        4'h0: mode_act = 5'b0_11_10;
        4'h1: mode_act = 5'b0_10_11;
        4'h2: mode_act = 5'b1_11_10;
        4'h3: mode_act = 5'b1_10_11;
        4'h4: mode_act = 5'b0_11_00;
        4'h5: mode_act = 5'b0_10_00;
        4'h6: mode_act = 5'b1_11_00;
        4'h7: mode_act = 5'b1_10_00;
        4'h8: mode_act = 5'b0_00_10;
        4'h9: mode_act = 5'b0_00_11;
        4'ha: mode_act = 5'b1_00_10;
        4'hb: mode_act = 5'b1_00_11;
        default: mode_act = 5'b0_11_10;
      endcase
    end
  endfunction

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer      i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  reg  [1:0]  ctrl_r;
  reg  [31:0] cfg_r [0:1];
  reg  [31:0] cyc_r [0:1];
  reg         wait_r;
  reg  [31:0] rdata_r;
  reg  [31:0] rdata_nxt;
  reg         download_r;
  wire        tick;
  wire [1:0]  obj_w;
  wire [1:0]  cond_w;
  wire [1:0]  busy_w;
  wire [31:0] thr_w;
  wire        wr_ok;

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = rdata_r;
  assign limit_o           = obj_w;
  assign wr_ok             = avs_write_i && !wait_r;

  blm_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (tick)
  ); // see RULE_20

  // One wait state: data is latched while waitrequest is high, taken when it drops
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= !((avs_read_i || avs_write_i) && wait_r);
      if (avs_read_i && wait_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address_i)
      `BLM_ADDR_CTRL:   rdata_nxt = {30'h0000_0000, ctrl_r};
      `BLM_ADDR_CFG0:   rdata_nxt = cfg_r[0];
      `BLM_ADDR_CYC0:   rdata_nxt = cyc_r[0];
      `BLM_ADDR_CFG1:   rdata_nxt = cfg_r[1];
      `BLM_ADDR_CYC1:   rdata_nxt = cyc_r[1];
      `BLM_ADDR_STATUS: rdata_nxt = {26'h000_0000, busy_w, cond_w, obj_w};
      `BLM_ADDR_THR0:   rdata_nxt = {16'h0000, thr_w[15:0]};
      `BLM_ADDR_THR1:   rdata_nxt = {16'h0000, thr_w[31:16]};
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r     <= `BLM_CTRL_RST;
      cfg_r[0]   <= `BLM_CFG_RST;
      cfg_r[1]   <= `BLM_CFG_RST;
      cyc_r[0]   <= `BLM_CYC_RST;
      cyc_r[1]   <= `BLM_CYC_RST;
      download_r <= 1'b0;
    end else begin
      download_r <= wr_ok && (avs_address_i == `BLM_ADDR_CTRL) && avs_byteenable_i[0]
                    && avs_writedata_i[`BLM_CTRL_DOWNLOAD];
      if (wr_ok) begin
        case (avs_address_i)
          `BLM_ADDR_CTRL: begin
            if (avs_byteenable_i[0]) begin
              ctrl_r <= avs_writedata_i[1:0];
            end
          end
          `BLM_ADDR_CFG0: cfg_r[0] <= be_merge(cfg_r[0], avs_writedata_i, avs_byteenable_i);
          `BLM_ADDR_CYC0: cyc_r[0] <= be_merge(cyc_r[0], avs_writedata_i, avs_byteenable_i);
          `BLM_ADDR_CFG1: cfg_r[1] <= be_merge(cfg_r[1], avs_writedata_i, avs_byteenable_i);
          `BLM_ADDR_CYC1: cyc_r[1] <= be_merge(cyc_r[1], avs_writedata_i, avs_byteenable_i);
          default: begin
          end
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      wire [31:0] cfg;
      wire [31:0] cyc;
      wire        exists;
      wire [15:0] thr;
      wire [15:0] hys;
      wire [4:0]  act;
      wire        a_lvl;
      wire        b_lvl;
      wire        tgt_en;
      wire        tgt_val;
      wire        want;
      wire [11:0] dly;
      wire        d_busy;
      wire        d_done;
      wire        accept;
      wire [6:0]  cyc_set;
      wire [11:0] period;
      wire        c_busy;
      wire        c_done;
      reg  [15:0] ext_thr_r;
      reg         ext_used_r;
      reg         cond_r;
      reg         obj_r;
      reg         send_r;

      assign cfg    = cfg_r[g];
      assign cyc    = cyc_r[g];
      assign exists = ctrl_r[`BLM_CTRL_ACTIVE]
                      && ((g == 0) || ctrl_r[`BLM_CTRL_LV2_EN]); // see RULE_15

      // An arrival in the download cycle wins, so the new value is not lost
      always @(posedge core_clk_i) begin
        if (rst_i) begin
          ext_thr_r  <= 16'h0000;
          ext_used_r <= 1'b0;
        end else if (teach_i[g] && (cfg[`BLM_CFG_EXT] == `BLM_EXT_TEACH)) begin
          ext_thr_r  <= brightness_i; // see RULE_01
          ext_used_r <= 1'b1;
        end else if (ext_wr_i[g] && (cfg[`BLM_CFG_EXT] == `BLM_EXT_16B)) begin
          ext_thr_r  <= ext_value_i; // see RULE_18
          ext_used_r <= 1'b1;
        end else if (ext_wr_i[g] && (cfg[`BLM_CFG_EXT] == `BLM_EXT_8B)) begin
          ext_thr_r  <= {8'h00, ext_value_i[7:0]}; // see RULE_18
          ext_used_r <= 1'b1;
        end else if (download_r) begin
          ext_used_r <= 1'b0; // see RULE_02
        end
      end

      assign thr = (ext_used_r && (cfg[`BLM_CFG_EXT] != `BLM_EXT_NONE)) ? ext_thr_r
                   : thr_klx(cfg[`BLM_CFG_THR]); // see RULE_14
      assign hys = hys_klx(cfg[`BLM_CFG_HYS]);
      assign act = mode_act(cfg[`BLM_CFG_MODE]); // see RULE_17

      // Hysteresis moves only the secondary crossing; sums are 17 bits to avoid wrap
      assign a_lvl = act[4] ? (brightness_i < thr) : (brightness_i > thr); // see RULE_16
      assign b_lvl = act[4] ? ({1'b0, brightness_i} > ({1'b0, thr} + {1'b0, hys}))
                            : (({1'b0, brightness_i} + {1'b0, hys}) < {1'b0, thr});

      always @(posedge core_clk_i) begin
        if (rst_i || !exists) begin
          cond_r <= 1'b0;
        end else if (a_lvl) begin
          cond_r <= 1'b1;
        end else if (b_lvl) begin
          cond_r <= 1'b0;
        end
      end

      assign tgt_en  = cond_r ? act[3] : act[1];
      assign tgt_val = cond_r ? act[2] : act[0];
      assign want    = exists && tgt_en && (tgt_val != obj_r);
      assign dly     = tgt_val ? delay_s(cfg[`BLM_CFG_OND])
                               : delay_s(cfg[`BLM_CFG_OFFD]); // see RULE_03 see RULE_05

      blm_sec_timer #(
        .W (12)
      ) u_dly (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick),
        .start_i    (want && !d_busy && !d_done && (dly != 12'h000)),
        .stop_i     (!want), // see RULE_19
        .secs_i     (dly),
        .busy_o     (d_busy),
        .done_o     (d_done)
      );

      assign accept = want && ((dly == 12'h000) || d_done);

      // Object holds its old value while a delay runs, so cyclic sends repeat it
      always @(posedge core_clk_i) begin
        if (rst_i || !exists) begin
          obj_r <= 1'b0;
        end else if (accept) begin
          obj_r <= tgt_val; // see RULE_04 see RULE_06
        end
      end

      assign cyc_set = (cyc[`BLM_CYC_INT] > `BLM_CYC_MAX) ? `BLM_CYC_MAX : cyc[`BLM_CYC_INT];
      assign period  = {5'h00, cyc_set} * `BLM_CYC_STEP_S; // see RULE_11

      blm_sec_timer #(
        .W (12)
      ) u_cyc (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick),
        .start_i    (exists && (cyc_set != 7'h00) && !c_busy), // see RULE_10
        .stop_i     (!exists || (cyc_set == 7'h00)), // see RULE_12
        .secs_i     (period),
        .busy_o     (c_busy),
        .done_o     (c_done)
      );

      always @(posedge core_clk_i) begin
        if (rst_i) begin
          send_r <= 1'b0;
        end else begin
          send_r <= exists && ((accept && cyc[`BLM_CYC_SOC])      // see RULE_08 see RULE_09
                    || (c_done && tgt_en && (cyc_set != 7'h00)));  // see RULE_07 see RULE_13
        end
      end

      assign obj_w[g]          = obj_r;
      assign cond_w[g]         = cond_r;
      assign busy_w[g]         = d_busy;
      assign send_o[g]         = send_r;
      assign thr_w[g*16 +: 16] = thr;
    end
  endgenerate

endmodule // blm_top

// *** test/blm_top_checker.sv ***
// Port assertions for the brightness limit monitor
`timescale 1ns/1ps
`include "blm_defines.vh"
module blm_top_checker #(
  parameter [31:0] TICK_CYCLES = 32'd20
) (
  input wire        core_clk_i,
  input wire        rst_i,
  input wire [7:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire [1:0]  limit_o,
  input wire [1:0]  send_o
);
  reg  soc_r;
  reg  cyc_r;
  reg  ch2_r;
  wire wr_done = avs_write_i && !avs_waitrequest_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of send settings; a write lands at the edge that ends its wait
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      soc_r <= 1'b0;
      cyc_r <= 1'b0;
      ch2_r <= 1'b0;
    end else if (wr_done) begin
      if (avs_address_i == `BLM_ADDR_CYC0 && avs_byteenable_i[1]) soc_r <= avs_writedata_i[8];
      if (avs_address_i == `BLM_ADDR_CYC0 && avs_byteenable_i[0]) cyc_r <= |avs_writedata_i[6:0];
      if (avs_address_i == `BLM_ADDR_CTRL && avs_byteenable_i[0]) ch2_r <= &avs_writedata_i[1:0];
    end
  end
  chk_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one wait state");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without a request");
  chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h04
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  chk_reset_idle: assert property ($fell(rst_i) |-> limit_o == 2'h0 && send_o == 2'h0)
    else $error("outputs not idle after reset");
  chk_soc_send: assert property (soc_r && $past(soc_r) && $changed(limit_o[0]) |-> send_o[0])
    else $error("state change not sent");
  chk_never_send: assert property (!soc_r && !cyc_r && !$past(soc_r) && !$past(cyc_r)
    |-> !send_o[0]) else $error("send with all sending off");
  chk_ch2_absent: assert property (!ch2_r && !$past(ch2_r) |-> !limit_o[1] && !send_o[1])
    else $error("absent channel two active");
endmodule // blm_top_checker

bind blm_top blm_top_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.core_clk_i, .rst_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .limit_o, .send_o);

// *** test/blm_bus_partner.sv ***
// Model of the bus devices that feed thresholds and receive the limit object
`timescale 1ns/1ps
module blm_bus_partner (
  input  wire        core_clk_i,
  input  wire [1:0]  limit_i,
  input  wire [1:0]  send_i,
  output wire [15:0] ext_value_o,
  output reg  [1:0]  ext_wr_o,
  output reg  [1:0]  teach_o
);
  reg [15:0] val_r = 16'h0;
  reg [15:0] noise_r = 16'hace1;
  reg        hold_r = 1'b0;
  int        sends = 0;
  int        ones = 0;
  int        last_t = 0;
  int        gap = 0;
  int        cyc = 0;
  // Idle value lines wander so a stale value never passes for a fresh one
  assign ext_value_o = hold_r ? val_r : noise_r;
  initial begin
    ext_wr_o = 2'h0;
    teach_o = 2'h0;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    noise_r <= {noise_r[14:0], ^(noise_r & 16'hb400)};
    if (send_i[0]) begin
      sends <= sends + 1;
      ones <= ones + limit_i[0];
      gap <= cyc - last_t;
      last_t <= cyc;
    end
  end
  // One-cycle arrival of a value object or a teach press
  task automatic put(input int ch, input logic [15:0] v, input logic tch);
    @(posedge core_clk_i);
    val_r <= v;
    hold_r <= 1'b1;
    if (tch) teach_o[ch] <= 1'b1;
    else ext_wr_o[ch] <= 1'b1;
    @(posedge core_clk_i);
    hold_r <= 1'b0;
    ext_wr_o <= 2'h0;
    teach_o <= 2'h0;
  endtask
endmodule // blm_bus_partner

// *** test/blm_top_tb_top.sv ***
// Self-checking bench for the brightness limit monitor
`timescale 1ns/1ps
`include "blm_defines.vh"
module blm_top_tb_top;
  localparam int   TK = 20;
  localparam [11:0] HI = 12'ha59;
  localparam [11:0] LO = 12'ha56;
  localparam [11:0] EX = 12'h333;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [15:0] brightness_i = 16'h0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  wire  [15:0] ext_value_i;
  wire  [1:0]  ext_wr_i, teach_i, limit_o, send_o;
  logic [31:0] q;
  int          n_fail = 0;
  int          tests_run = 0;
  int          s0, o0, md, k, v, p;
  int          cds[4] = '{0, 1, 21, 31};
  always #2 core_clk_i = ~core_clk_i;
  blm_top #(.TICK_CYCLES(TK)) dut_u (.core_clk_i, .rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .brightness_i, .ext_value_i, .ext_wr_i, .teach_i, .limit_o, .send_o);
  blm_bus_partner pm_u (.core_clk_i, .limit_i(limit_o), .send_i(send_o),
    .ext_value_o(ext_value_i), .ext_wr_o(ext_wr_i), .teach_o(teach_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic bri(input logic [15:0] b);
    @(posedge core_clk_i);
    brightness_i <= b;
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] cy);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    wt(16);
    rst_i <= 1'b0;
    bus(1'b1, `BLM_ADDR_CTRL, 32'h1);
    bus(1'b1, `BLM_ADDR_CFG0, c);
    bus(1'b1, `BLM_ADDR_CYC0, cy);
  endtask
  // Hysteresis fixed at 2 kLux so thresholds sit at 8, 10 and 12
  function automatic logic [31:0] cw(input logic [4:0] t, input logic [3:0] m,
                                     input logic [1:0] e, input logic [3:0] on, input logic [3:0] off);
    return {4'h0, off, on, 2'h0, e, m, 4'h2, 3'h0, t};
  endfunction
  function automatic logic [31:0] te(input logic [4:0] c);
    return (c == 5'h0) ? 32'h3 : (c > 5'h15) ? 32'h69 : 32'(c) * 32'h5;
  endfunction
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_fail++;
    end_of_test;
  end
  initial begin
    k = $urandom(32'h1b5d6eec);
    setup(32'h0, 32'h0);
    rdc(`BLM_ADDR_STATUS, 32'h0);
    rdc(`BLM_ADDR_CYC0, 32'h0);
    bus(1'b1, 8'h04, 32'hffff_ffff);
    rdc(8'h04, 32'h0);
    for (k = 0; k < 8; k++) begin
      md = (k < 4) ? cds[k] : $urandom_range(21);
      bus(1'b1, `BLM_ADDR_CFG0, cw(5'(md), 4'h0, 2'h0, 4'h0, 4'h0));
      rdc(`BLM_ADDR_THR0, te(5'(md)));
    end
    for (md = 0; md < 12; md++) begin
      setup(cw(5'h2, 4'(md), 2'h0, 4'h0, 4'h0), 32'h100);
      bri(16'($urandom_range(6)));
      wt(4);
      bri(16'($urandom_range(60, 13)));
      wt(4);
      check(limit_o[0], HI[md]);
      bri(16'h9);
      wt(4);
      check(limit_o[0], EX[md] ? HI[md] : LO[md]);
      bri(16'($urandom_range(6)));
      wt(4);
      check(limit_o[0], LO[md]);
    end
    setup(cw(5'h2, 4'h0, 2'h0, 4'h0, 4'h0), 32'h0);
    s0 = pm_u.sends;
    bri(16'h1e);
    wt(4);
    bri(16'h0);
    wt(4);
    check(pm_u.sends - s0, 0);
    k = $urandom_range(2, 1);
    p = k * 10 * TK;
    setup(cw(5'h2, 4'h0, 2'h0, 4'h0, 4'h0), 32'(k));
    wt(3 * p + 40);
    check(pm_u.gap >= p && pm_u.gap <= p + 1, 1);
    bus(1'b1, `BLM_ADDR_CYC0, 32'h0);
    wt(2);
    s0 = pm_u.sends;
    wt(2 * p);
    check(pm_u.sends - s0, 0);
    bri(16'h0);
    setup(cw(5'h2, 4'h4, 2'h0, 4'h0, 4'h0), 32'h1);
    s0 = pm_u.sends;
    wt(30 * TK);
    check(pm_u.sends - s0, 0);
    bri(16'h1e);
    wt(30 * TK);
    check(pm_u.sends - s0 >= 2, 1);
    bri(16'h0);
    setup(cw(5'h2, 4'h0, 2'h0, 4'h7, 4'h7), 32'h1);
    s0 = pm_u.sends;
    o0 = pm_u.ones;
    bri(16'h1e);
    wt(55 * TK);
    check(limit_o[0], 1'b0);
    check(pm_u.sends - s0 >= 4 && pm_u.ones == o0, 1);
    wt(10 * TK);
    check(limit_o[0], 1'b1);
    bri(16'h0);
    s0 = pm_u.sends;
    o0 = pm_u.ones;
    wt(55 * TK);
    check(limit_o[0], 1'b1);
    check(pm_u.ones - o0 == pm_u.sends - s0, 1);
    wt(10 * TK);
    check(limit_o[0], 1'b0);
    setup(cw(5'h2, 4'h0, 2'h0, 4'h4, 4'h0), 32'h0);
    bri(16'h1e);
    wt(TK / 2);
    bri(16'h0);
    wt(3 * TK);
    rdc(`BLM_ADDR_STATUS, 32'h0);
    setup(cw(5'h4, 4'h0, 2'h3, 4'h0, 4'h0), 32'h0);
    v = $urandom_range(100);
    bri(16'(v));
    pm_u.put(0, 16'h0, 1'b1);
    rdc(`BLM_ADDR_THR0, 32'(v));
    bus(1'b1, `BLM_ADDR_CFG0, cw(5'h4, 4'h0, 2'h1, 4'h0, 4'h0));
    v = $urandom;
    pm_u.put(0, 16'(v), 1'b0);
    rdc(`BLM_ADDR_THR0, 32'(v[15:0]));
    pm_u.put(0, 16'h0, 1'b1);
    rdc(`BLM_ADDR_THR0, 32'(v[15:0]));
    bus(1'b1, `BLM_ADDR_CFG0, cw(5'h4, 4'h0, 2'h2, 4'h0, 4'h0));
    pm_u.put(0, 16'(v >> 3), 1'b0);
    rdc(`BLM_ADDR_THR0, 32'((v >> 3) & 8'hff));
    bus(1'b1, `BLM_ADDR_CTRL, 32'h5);
    rdc(`BLM_ADDR_THR0, te(5'h4));
    bus(1'b1, `BLM_ADDR_CFG1, cw(5'h2, 4'h0, 2'h0, 4'h0, 4'h0));
    bri(16'h1e);
    wt(4);
    check(limit_o[1], 1'b0);
    bus(1'b1, `BLM_ADDR_CTRL, 32'h3);
    wt(4);
    check(limit_o[1], 1'b1);
    end_of_test;
  end
endmodule // blm_top_tb_top
